// ---- zqc_ctl.sv ----
`timescale 1ns/1ps
// ****************************************
// Controller end: precharge, wait, calibrate, keep quiet
// ****************************************
module zqc_ctl #(
  parameter int unsigned TZQINIT = zqc_pkg::TZQINIT_NCK,
  parameter int unsigned TZQOPER = zqc_pkg::TZQOPER_NCK,
  parameter int unsigned TZQCS   = zqc_pkg::TZQCS_NCK,
  parameter int unsigned TRP     = zqc_pkg::TRP_NCK,
  parameter int unsigned TXS     = zqc_pkg::TXS_NCK
) (
  input  wire logic clk,
  input  wire logic rst,
  zqc_if.ctl        bus,
  input  wire logic req_valid,
  input  wire logic req_long,
  input  wire logic sr_exit,
  input  wire logic zq_grant,
  output logic      req_ready,
  output logic      cal_busy,
  output logic      done
);
  typedef enum logic [1:0] {SC_IDLE, SC_PRE, SC_ZQ, SC_WAIT} zqc_cst_t;
  typedef struct packed {
    zqc_cst_t                  st;
    logic [zqc_pkg::CNT_W-1:0] cnt;
    logic [zqc_pkg::CNT_W-1:0] xs;
    logic                      first_done;
    logic                      is_long;
    logic [3:0]                cmd;
    logic                      a10;
    logic                      done;
    logic                      ready;
    logic                      busy;
  } zqc_ctl_t;
  zqc_ctl_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.cmd  = zqc_pkg::CMD_NOP;
    s_d.a10  = 1'b0;
    s_d.done = 1'b0;
    if (sr_exit) begin
      s_d.xs = zqc_pkg::CNT_W'(TXS);
    end else if (s_q.xs != '0) begin
      s_d.xs = s_q.xs - zqc_pkg::CNT_W'(1);
    end
    unique case (s_q.st)
      SC_IDLE: begin
        // tXS is waited out only after a self-refresh exit in an earlier cycle; shared resistor must be granted
        if (req_valid && s_q.xs == '0 && zq_grant) begin
          s_d.is_long = req_long || !s_q.first_done;
          s_d.cmd     = zqc_pkg::CMD_PRE;
          s_d.a10     = 1'b1;
          s_d.cnt     = zqc_pkg::CNT_W'(TRP);
          s_d.st      = SC_PRE;
        end
      end
      SC_PRE: begin
        if (s_q.cnt == '0) begin
          s_d.cmd = zqc_pkg::CMD_ZQ;
          s_d.a10 = s_q.is_long;
          s_d.st  = SC_ZQ;
        end else begin
          s_d.cnt = s_q.cnt - zqc_pkg::CNT_W'(1);
        end
      end
      SC_ZQ: begin
        s_d.cnt = !s_q.is_long ? zqc_pkg::CNT_W'(TZQCS) :
                  (s_q.first_done ? zqc_pkg::CNT_W'(TZQOPER) : zqc_pkg::CNT_W'(TZQINIT));
        s_d.st  = SC_WAIT;
      end
      SC_WAIT: begin
        // Only NOPs go out until the whole window has passed
        if (s_q.cnt <= zqc_pkg::CNT_W'(1)) begin
          s_d.st   = SC_IDLE;
          s_d.done = 1'b1;
          if (s_q.is_long) begin
            s_d.first_done = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt - zqc_pkg::CNT_W'(1);
        end
      end
    endcase
    // Flags are taken from the next state so the outputs leave a flip-flop
    s_d.ready = (s_d.st == SC_IDLE) && (s_d.xs == '0);
    s_d.busy  = (s_d.st != SC_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st         <= SC_IDLE;
      s_q.cnt        <= '0;
      s_q.xs         <= '0;
      s_q.first_done <= 1'b0;
      s_q.is_long    <= 1'b0;
      s_q.cmd        <= zqc_pkg::CMD_NOP;
      s_q.a10        <= 1'b0;
      s_q.done       <= 1'b0;
      s_q.ready      <= 1'b1;
      s_q.busy       <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.cke       = 1'b1;
  assign bus.odt       = 1'b0;
  assign bus.dq_oe_ctl = 1'b0;
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = s_q.cmd;
  assign bus.addr      = {4'h0, s_q.a10, 10'h000};
  assign req_ready     = s_q.ready;
  assign cal_busy      = s_q.busy;
  assign done          = s_q.done;
endmodule // zqc_ctl

// ---- zqc_pkg.sv ----
package zqc_pkg;
  // Command encodings on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ZQ    = 4'h6;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  localparam int unsigned A10_POS  = 10;
  localparam int unsigned CLK_PS   = 8000;
  // Calibration windows in clock cycles of the command clock
  localparam int unsigned TZQINIT_NCK = 512;
  localparam int unsigned TZQOPER_NCK = 256;
  localparam int unsigned TZQCS_NCK   = 64;
  localparam int unsigned TRP_NCK     = 14;
  localparam int unsigned TXS_NCK     = 216;
  localparam int unsigned CNT_W       = 10;
  // Impedance code width and correction step per engine strobe
  localparam int unsigned CODE_W      = 6;
  localparam logic [5:0]  CODE_RST    = 6'h20;
  localparam logic [5:0]  CODE_STEP   = 6'h01;
  typedef enum logic [1:0] {ZQC_NONE, ZQC_LONG, ZQC_SHORT} zqc_kind_t;
endpackage

// ---- zqc_if.sv ----
`timescale 1ns/1ps
interface zqc_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [14:0] addr;
  logic        odt;
  logic        dq_oe_ctl;
  logic        dq_oe_dev;
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, addr, odt, dq_oe_ctl, input dq_oe_dev);
  modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, odt, dq_oe_ctl, output dq_oe_dev);
endinterface

// ---- zqc_engine.sv ----
`timescale 1ns/1ps
// ****************************************
// Calibration engine: walks the code toward the target
// ****************************************
module zqc_engine #(
  parameter int unsigned CODE_W = zqc_pkg::CODE_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              step,
  input  wire logic [CODE_W-1:0] target,
  output logic      [CODE_W-1:0] code_q
);
  typedef struct packed {
    logic [CODE_W-1:0] code;
  } zqc_eng_t;
  zqc_eng_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    // One step per strobe is the least correction a short command makes
    if (step && s_q.code < target) begin
      s_d.code = s_q.code + CODE_W'(zqc_pkg::CODE_STEP);
    end else if (step && s_q.code > target) begin
      s_d.code = s_q.code - CODE_W'(zqc_pkg::CODE_STEP);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.code <= CODE_W'(zqc_pkg::CODE_RST);
    end else begin
      s_q <= s_d;
    end
  end

  assign code_q = s_q.code;
endmodule // zqc_engine

// ---- zqc_dev.sv ----
`timescale 1ns/1ps
// Behaviour
// - Long calibration accepted at any time; the model takes it only in idle, not while a window runs
// - Engine runs, result moves into IO
// - Long done in init or oper window
// - Short done within short window
// - Short corrects at least one step
// - Controller keeps channel quiet meanwhile
// - Calibration current path off when done
// - Controller precharges, waits tRP first
// - Command accepted during DLL lock
// - No calibration started on its own
// - Controller waits tXS after self refresh; the model skips it for a request taken in the same cycle as the exit
// - Shared resistor windows never overlap
// - Clock enable held high throughout
// - Termination disabled during calibration
// - All DQ drivers off during calibration
module zqc_dev #(
  parameter int unsigned TZQINIT = zqc_pkg::TZQINIT_NCK,
  parameter int unsigned TZQOPER = zqc_pkg::TZQOPER_NCK,
  parameter int unsigned TZQCS   = zqc_pkg::TZQCS_NCK
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  zqc_if.dev                              bus,
  input  wire logic [zqc_pkg::CODE_W-1:0] target_code,
  output logic                            busy,
  output logic                            zq_current_en,
  output logic                            first_done,
  output logic      [zqc_pkg::CODE_W-1:0] io_code
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LONG, ST_SHORT} zqc_dst_t;
  typedef struct packed {
    zqc_dst_t                   st;
    logic [zqc_pkg::CNT_W-1:0]  cnt;
    logic                       first_done;
    logic                       busy;
    logic                       cur_en;
    logic [zqc_pkg::CODE_W-1:0] io_code;
  } zqc_dev_t;
  zqc_dev_t s_q, s_d;

  logic                       zq_cmd;
  logic                       zq_long;
  logic                       eng_step;
  logic [zqc_pkg::CODE_W-1:0] eng_code;
  logic [zqc_pkg::CNT_W-1:0]  win;

  // ****************************************
  // Command decode
  // ****************************************
  // Calibration only ever starts from a command; self-refresh exit has no hook
  assign zq_cmd = bus.cke &&
                  ({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} == zqc_pkg::CMD_ZQ);
  assign zq_long = bus.addr[zqc_pkg::A10_POS];
  // Only the first long command after reset gets the init window
  assign win = !zq_long ? zqc_pkg::CNT_W'(TZQCS) :
               (s_q.first_done ? zqc_pkg::CNT_W'(TZQOPER) : zqc_pkg::CNT_W'(TZQINIT));
  // The engine tracks only inside a window; between windows the code is frozen
  assign eng_step = (s_q.st != ST_IDLE);
  // Data drivers stay off; the quiet channel is what calibration measures against
  assign bus.dq_oe_dev = 1'b0;

  // ****************************************
  // Calibration engine
  // ****************************************
  zqc_engine #(.CODE_W(zqc_pkg::CODE_W)) zqc_engine_inst (
    .clk    (clk),
    .rst    (rst),
    .step   (eng_step),
    .target (target_code),
    .code_q (eng_code)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      ST_IDLE: begin
        // Accepted in idle, including while the DLL relocks
        if (zq_cmd) begin
          s_d.st     = zq_long ? ST_LONG : ST_SHORT;
          s_d.cnt    = win - zqc_pkg::CNT_W'(1);
          s_d.busy   = 1'b1;
          s_d.cur_en = 1'b1;
        end
      end
      ST_LONG, ST_SHORT: begin
        if (s_q.cnt == '0) begin
          // Transfer lands at the window end, so drivers never change mid-window
          s_d.io_code = eng_code;
          s_d.st      = ST_IDLE;
          s_d.busy    = 1'b0;
          s_d.cur_en  = 1'b0;
          if (s_q.st == ST_LONG) begin
            s_d.first_done = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt - zqc_pkg::CNT_W'(1);
        end
      end
      default: begin
        // The unused state code falls back to idle rather than locking up
        s_d.st     = ST_IDLE;
        s_d.busy   = 1'b0;
        s_d.cur_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st         <= ST_IDLE;
      s_q.cnt        <= '0;
      s_q.first_done <= 1'b0;
      s_q.busy       <= 1'b0;
      s_q.cur_en     <= 1'b0;
      s_q.io_code    <= zqc_pkg::CODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy          = s_q.busy;
  assign zq_current_en = s_q.cur_en;
  assign first_done    = s_q.first_done;
  assign io_code       = s_q.io_code;
endmodule // zqc_dev

// ---- zqc_asserts.sv ----
`timescale 1ns/1ps
// ***
// Channel checks
// ***
module zqc_asserts #(
  parameter int TZQINIT = 16,
  parameter int TZQOPER = 8,
  parameter int TZQCS   = 4,
  parameter int TRP     = 3
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [14:0] addr,
  input wire logic        odt,
  input wire logic        dq_oe_ctl,
  input wire logic        dq_oe_dev
);
  localparam int ZQ_LAT = TRP + 1;
  logic [3:0] cmd;
  logic [9:0] gap_q;
  logic [9:0] quiet_q;
  logic       first_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // Quiet count reloads on each calibration, sized by which window applies
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q   <= '0;
      quiet_q <= '0;
      first_q <= 1'b1;
    end else begin
      gap_q <= (cmd == zqc_pkg::CMD_PRE) ? '0 : gap_q + 10'h001;
      if (cmd == zqc_pkg::CMD_ZQ) begin
        quiet_q <= !addr[10] ? 10'(TZQCS) : (first_q ? 10'(TZQINIT) : 10'(TZQOPER));
        first_q <= 1'b0;
      end else if (quiet_q != '0) begin
        quiet_q <= quiet_q - 10'h001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  cke_high_a: assert property (cke) else $error("cke low");
  odt_off_a: assert property (!odt) else $error("odt on");
  dq_hiz_a: assert property (!dq_oe_ctl && !dq_oe_dev) else $error("dq driven");
  pre_all_a: assert property (cmd == zqc_pkg::CMD_PRE |-> addr[10]) else $error("pre not all");
  pre_gap_a: assert property (cmd == zqc_pkg::CMD_ZQ |-> gap_q >= 10'(TRP)) else $error("trp short");
  pre_zq_a: assert property (cmd == zqc_pkg::CMD_PRE |-> ##ZQ_LAT cmd == zqc_pkg::CMD_ZQ) else $error("no zq");
  quiet_chan_a: assert property (quiet_q != '0 |-> cs_n || cmd == zqc_pkg::CMD_NOP) else $error("noisy");
  first_long_a: assert property (cmd == zqc_pkg::CMD_ZQ && first_q |-> addr[10]) else $error("first short");
endmodule // zqc_asserts

// ---- test_dram_zq_calibration_sequencing.sv ----
`timescale 1ns/1ps
// ***
// Both ends joined
// ***
module test_dram_zq_calibration_sequencing;
  typedef struct packed {logic l; logic [5:0] t; logic [9:0] w;} zqc_row_t;
  logic       clk, rst, req_v, req_l, sr_x, grant, ready, cbusy, done, busy, cur_en, first;
  logic [5:0] target, io_code;
  int         fail_count, check_count, n;
  // Short windows keep the run brief; only the init-to-oper ratio of 2 follows the real ones, the short window is half of oper
  localparam int unsigned T_INIT = 16;
  localparam int unsigned T_OPER = 8;
  localparam int unsigned T_CS   = 4;
  localparam int unsigned T_RP   = 3;
  localparam int unsigned T_XS   = 10;
  // First request is short on purpose: the controller must force it long
  zqc_row_t   rows [4] = '{'{1'h0, 6'h2C, 10'h010}, '{1'h1, 6'h2C, 10'h008},
                           '{1'h0, 6'h10, 10'h004}, '{1'h1, 6'h3F, 10'h008}};
  zqc_if bus();
  zqc_dev #(.TZQINIT(T_INIT), .TZQOPER(T_OPER), .TZQCS(T_CS)) zqc_dev_inst (.clk, .rst, .bus(bus),
    .target_code(target), .busy(busy), .zq_current_en(cur_en), .first_done(first), .io_code(io_code));
  zqc_ctl #(.TZQINIT(T_INIT), .TZQOPER(T_OPER), .TZQCS(T_CS), .TRP(T_RP), .TXS(T_XS)) zqc_ctl_inst (.clk, .rst,
    .bus(bus), .req_valid(req_v), .req_long(req_l), .sr_exit(sr_x), .zq_grant(grant), .req_ready(ready),
    .cal_busy(cbusy), .done(done));
  zqc_asserts #(.TZQINIT(T_INIT), .TZQOPER(T_OPER), .TZQCS(T_CS), .TRP(T_RP)) zqc_asserts_inst (.clk, .rst,
    .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .addr(bus.addr),
    .odt(bus.odt), .dq_oe_ctl(bus.dq_oe_ctl), .dq_oe_dev(bus.dq_oe_dev));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [9:0] s, input logic [9:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask
  task final_report;
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tmo;
    if (n >= 400) begin
      fail_count++;
      final_report;
    end
  endtask
  function automatic logic [5:0] dd(input logic [5:0] a, input logic [5:0] b);
    return (a > b) ? a - b : b - a;
  endfunction
  task run(input zqc_row_t r);
    logic [5:0] b;
    logic [9:0] w;
    @(negedge clk);
    b = io_code;
    req_v = 1'b1;
    req_l = r.l;
    target = r.t;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    tmo;
    @(negedge clk);
    req_v = 1'b0;
    while (busy !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    tmo;
    w = '0;
    while (busy === 1'b1 && w < 10'h3FF) begin
      check({cur_en, cbusy}, 2'h3);
      @(negedge clk);
      w++;
    end
    if (w == 10'h3FF) begin
      fail_count++;
      final_report;
    end
    check(w, r.w);
    check(cur_en, 1'h0);
    check({cbusy, done}, 2'h1);
    check(first, 1'h1);
    check(io_code == r.t || dd(io_code, r.t) < dd(b, r.t), 1'h1);
  endtask
  initial begin
    rst = 1'b1;
    req_v = 1'b0;
    req_l = 1'b0;
    sr_x = 1'b0;
    grant = 1'b1;
    target = 6'h2C;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check(io_code, zqc_pkg::CODE_RST);
    check({first, busy, cur_en, cbusy, done, ready}, 6'h01);
    foreach (rows[i]) run(rows[i]);
    // Without the shared-resistor grant nothing may start
    grant = 1'b0;
    req_v = 1'b1;
    repeat (12) begin
      @(negedge clk);
      check({cbusy, busy}, 2'h0);
    end
    req_v = 1'b0;
    grant = 1'b1;
    sr_x = 1'b1;
    @(negedge clk);
    sr_x = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      check(busy, 1'h0);
      @(negedge clk);
      n++;
    end
    tmo;
    check(n >= T_XS, 1'h1);
    run('{1'h0, 6'h20, 10'h004});
    // A second reset must bring back the long init window for the next request
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({first, io_code}, {1'h0, zqc_pkg::CODE_RST});
    run('{1'h0, 6'h24, 10'(T_INIT)});
    final_report;
  end
endmodule // test_dram_zq_calibration_sequencing
